// ===== inc/nip_regs.vh
// constants of the nested interrupt priority controller
// assumes plain verilog-2005 and inclusion by bare name
`ifndef NIP_REGS_VH
`define NIP_REGS_VH

// ****************************************************************
// priority level codes
// ****************************************************************
`define NIP_LVL_ZERO 2'h0
`define NIP_LVL_ONE 2'h1
`define NIP_LVL_TWO 2'h2
`define NIP_LVL_THREE 2'h3
`define NIP_LVL_RESET 2'h3

// ****************************************************************
// source indices
// ****************************************************************
`define NIP_NSRC 19
`define NIP_SRC_CLOCK 5'h00
`define NIP_SRC_EXT0 5'h01
`define NIP_SRC_EXT1 5'h02
`define NIP_SRC_EXT2 5'h03
`define NIP_SRC_EXT3 5'h04
`define NIP_SRC_CAN 5'h05
`define NIP_SRC_SPI 5'h06
`define NIP_SRC_TIMA 5'h07
`define NIP_SRC_TIMB 5'h08
`define NIP_SRC_SER 5'h09
`define NIP_SRC_VDET 5'h0A
`define NIP_SRC_I2C 5'h0B
`define NIP_SRC_PWM 5'h0C
`define NIP_SRC_XFER 5'h0D
`define NIP_SRC_PLUG 5'h0E
`define NIP_SRC_ESUSP 5'h0F
`define NIP_SRC_USB 5'h10
`define NIP_SRC_ADC 5'h11
`define NIP_SRC_CFLT 5'h12
// sources with no exit from halt: timers a/b, serial, i2c, xfer, usb
`define NIP_NOWAKE_MASK 19'h12B80

// ****************************************************************
// external control/status register
// ****************************************************************
`define NIP_EXT_CSR_W 8
`define NIP_EXT_CSR_RESET 8'h00
`endif

// ===== rtl/nip_pick.v
// highest-priority pending source finder
// assumes levels packed two bits per source, source 0 in the low bits
`timescale 1ns/1ps
`include "nip_regs.vh"

module nip_pick #(
  parameter NSRC = `NIP_NSRC
) (
  // requests and levels
  input wire [NSRC-1:0] req,
  input wire [2*NSRC-1:0] lvl,
  // winner
  output reg found,
  output reg [4:0] idx,
  output reg [1:0] win_lvl
);
  integer i;
  // lowest index wins a tie between equal levels
  always @* begin
    found = 1'b0;
    idx = 5'h00;
    win_lvl = `NIP_LVL_ZERO;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (req[i] && (!found || lvl[2*i +: 2] >= win_lvl)) begin
        found = 1'b1;
        idx = i[4:0];
        win_lvl = lvl[2*i +: 2];
      end
    end
  end
endmodule

// ===== rtl/nip_ctrl.v
// nested interrupt priority controller, top level
// assumes the core acks a forwarded request with irq_ack and signals
// handler return with irq_ret; all inputs synchronous to core_clk
`timescale 1ns/1ps
`include "nip_regs.vh"

module nip_ctrl #(
  parameter NSRC = `NIP_NSRC,
  parameter DEPTH = 4
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // interrupt sources and their enables
  input wire [NSRC-1:0] src_irq,
  input wire [NSRC-1:0] src_en,
  // software priority programming
  input wire set_prio_we,
  input wire [NSRC-1:0] set_prio_sel,
  input wire [1:0] set_prio_lvl,
  input wire [4:0] get_prio_sel,
  input wire init_strobe,
  // external interrupt control/status register
  input wire ext_csr_we,
  input wire [`NIP_EXT_CSR_W-1:0] ext_csr_wdata,
  // core handshake
  input wire trap_req,
  input wire irq_ack,
  input wire irq_ret,
  input wire halt_mode,
  // outputs to core and software
  output reg irq_req_r,
  output reg [4:0] irq_idx_r,
  output reg [1:0] irq_lvl_r,
  output reg trap_take_r,
  output reg reenter_r,
  output reg [1:0] cur_lvl_r,
  output reg [1:0] get_prio_r,
  output reg wake_r,
  output reg [`NIP_EXT_CSR_W-1:0] ext_csr_r
);
  // ****************************************************************
  // storage
  // ****************************************************************
  reg [2*NSRC-1:0] prio_r;
  wire [2*NSRC-1:0] prio_nxt;
  // stack of preempted levels and running sources
  reg [2*DEPTH-1:0] lvl_stk_r;
  reg [5*DEPTH-1:0] idx_stk_r;
  reg [2:0] sp_r;
  reg run_valid_r;
  reg [4:0] run_idx_r;

  wire [NSRC-1:0] pend = src_irq & src_en;
  wire [NSRC-1:0] nowake = `NIP_NOWAKE_MASK;
  wire [4:0] win_idx;
  wire [1:0] win_lvl;

  nip_pick #(.NSRC(NSRC)) u_pick (
    .req(pend),
    .lvl(prio_r),
    .found(),
    .idx(win_idx),
    .win_lvl(win_lvl)
  );

  // ****************************************************************
  // priority registers
  // ****************************************************************
  // init wins over a write landing in the same cycle
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_prio
      wire wr_hit = set_prio_we && set_prio_sel[g] &&
                    set_prio_lvl != `NIP_LVL_ZERO;
      assign prio_nxt[2*g +: 2] =
        init_strobe ? `NIP_LVL_RESET :
        wr_hit ? set_prio_lvl :
        prio_r[2*g +: 2];
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!rstn)
      prio_r <= {NSRC{`NIP_LVL_RESET}};
    else
      prio_r <= prio_nxt;
  end

  // ****************************************************************
  // external control/status register
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rstn)
      ext_csr_r <= `NIP_EXT_CSR_RESET;
    else if (init_strobe)
      ext_csr_r <= `NIP_EXT_CSR_RESET;
    else if (ext_csr_we)
      ext_csr_r <= ext_csr_wdata;
  end

  // ****************************************************************
  // level readback
  // ****************************************************************
  // indices past the last source read as level zero
  wire sel_ok = get_prio_sel < NSRC[4:0];
  always @(posedge core_clk) begin
    if (!rstn)
      get_prio_r <= `NIP_LVL_RESET;
    else if (sel_ok)
      get_prio_r <= prio_r[2*get_prio_sel +: 2];
    else
      get_prio_r <= `NIP_LVL_ZERO;
  end

  // ****************************************************************
  // per-source eligibility
  // ****************************************************************
  wire [NSRC-1:0] above;
  wire [NSRC-1:0] wake_src;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_elig
      // a level equal to the running one never preempts
      assign above[g] = pend[g] && prio_r[2*g +: 2] > cur_lvl_r;
      assign wake_src[g] = pend[g] && !nowake[g];
    end
  endgenerate
  wire any_above = |above;
  wire any_wake = |wake_src;

  // ****************************************************************
  // stack and re-entry helpers
  // ****************************************************************
  wire stk_full = sp_r == DEPTH[2:0];
  wire stk_empty = sp_r == 3'h0;
  // a full stack refuses the ack; no request is raised until a return
  wire do_push = irq_ack && irq_req_r && !stk_full;
  wire do_pop = irq_ret && !stk_empty;
  wire [2:0] sp_dec = sp_r - 3'h1;
  wire [1:0] top_lvl = lvl_stk_r[2*sp_dec +: 2];
  wire [4:0] top_idx = idx_stk_r[5*sp_dec +: 5];
  // only a real write to the running source may re-enter it; init
  // restores the defaults without touching the running level
  wire [1:0] run_prio = prio_r[2*run_idx_r +: 2];
  wire [1:0] run_new = prio_nxt[2*run_idx_r +: 2];
  wire run_written = set_prio_we && !init_strobe &&
                     set_prio_sel[run_idx_r];
  wire run_raised = run_valid_r && run_written && pend[run_idx_r] &&
                    run_new > cur_lvl_r && run_new != run_prio;

  // ****************************************************************
  // nesting, forwarding and re-entry
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      irq_req_r <= 1'b0;
      irq_idx_r <= 5'h00;
      irq_lvl_r <= `NIP_LVL_ZERO;
      trap_take_r <= 1'b0;
      reenter_r <= 1'b0;
      cur_lvl_r <= `NIP_LVL_ZERO;
      lvl_stk_r <= {2*DEPTH{1'b0}};
      idx_stk_r <= {5*DEPTH{1'b0}};
      sp_r <= 3'h0;
      run_valid_r <= 1'b0;
      run_idx_r <= 5'h00;
      wake_r <= 1'b0;
    end else begin
      trap_take_r <= trap_req;
      reenter_r <= 1'b0;
      wake_r <= halt_mode && any_wake;
      if (do_push) begin
        // core took the forwarded request: push and raise level
        lvl_stk_r[2*sp_r +: 2] <= cur_lvl_r;
        idx_stk_r[5*sp_r +: 5] <= run_idx_r;
        sp_r <= sp_r + 3'h1;
        cur_lvl_r <= irq_lvl_r;
        run_idx_r <= irq_idx_r;
        run_valid_r <= 1'b1;
        irq_req_r <= 1'b0;
      end else if (do_pop) begin
        // handler return: restore the preempted level and source
        lvl_stk_r[2*sp_dec +: 2] <= `NIP_LVL_ZERO;
        cur_lvl_r <= top_lvl;
        run_idx_r <= top_idx;
        run_valid_r <= sp_r != 3'h1;
        sp_r <= sp_dec;
        irq_req_r <= 1'b0;
      end else if (run_raised) begin
        // level raised while pending: re-enter at the new level
        cur_lvl_r <= run_new;
        reenter_r <= 1'b1;
        irq_req_r <= 1'b0;
      end else if (any_above && !stk_full) begin
        // a lowered or unchanged level leaves cur_lvl_r alone
        irq_req_r <= 1'b1;
        irq_idx_r <= win_idx;
        irq_lvl_r <= win_lvl;
      end else begin
        irq_req_r <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/nip_chk.sv
// port assertions for the nested priority controller
// assumes a bind into nip_ctrl and one clock domain
`timescale 1ns/1ps
module nip_chk (
  // clock, reset and inputs
  input wire core_clk,
  input wire rstn,
  input wire set_prio_we,
  input wire trap_req,
  input wire irq_ack,
  input wire irq_ret,
  // outputs
  input wire irq_req_r,
  input wire [1:0] irq_lvl_r,
  input wire trap_take_r,
  input wire reenter_r,
  input wire [1:0] cur_lvl_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_trap_take: assert property (trap_req |=> trap_take_r)
    else $error("trap lost");
  a_trap_cause: assert property (trap_take_r |-> $past(trap_req))
    else $error("stray trap");
  a_req_above: assert property (
    irq_req_r |-> irq_lvl_r > $past(cur_lvl_r)) else $error("low req");
  a_ack_drop: assert property (irq_ack && irq_req_r |=> !irq_req_r)
    else $error("req held");
  a_ack_level: assert property (
    irq_ack && irq_req_r |=> cur_lvl_r == $past(irq_lvl_r)) else $error("lv");
  // a priority write may act one or two edges later
  a_lvl_hold: assert property (
    $stable(cur_lvl_r) || $past(irq_ack || irq_ret || set_prio_we) ||
    $past(set_prio_we, 2)) else $error("lvl moved");
  a_reenter_up: assert property (
    reenter_r |-> cur_lvl_r > $past(cur_lvl_r)) else $error("no raise");
  a_reenter_src: assert property (
    reenter_r |-> $past(set_prio_we) || $past(set_prio_we, 2))
    else $error("stray reenter");
endmodule
bind nip_ctrl nip_chk u_chk (.*);

// ===== tb/nip_core_model.sv
// core-side model: answers forwarded requests with a one-cycle ack
// assumes the request drops the cycle after the ack edge
`timescale 1ns/1ps
module nip_core_model (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // request in, ack out; ack_en low stalls like a busy core
  input wire irq_req_r,
  input wire ack_en,
  output reg irq_ack
);
  always @(posedge core_clk) begin
    if (!rstn) irq_ack <= 1'h0;
    // no second ack while the acked request is still visible
    else irq_ack <= irq_req_r && ack_en && !irq_ack;
  end
endmodule

// ===== tb/testbench.sv
// bench: priority programming, nesting, trap, wake and init
// assumes nip_core_model answers the request handshake
`timescale 1ns/1ps
module testbench;
  reg core_clk = 0, rstn = 0, we = 0, init = 0, trap = 0;
  reg ret = 0, halt = 0, aen = 0, ew = 0;
  reg [7:0] ewd = 0;
  reg [18:0] irq = 0, sel = 0;
  reg [18:0] en = 19'h7FFFF;
  reg [1:0] lvl = 0;
  reg [4:0] gsel = 0;
  wire ack, req, tt, wk, re;
  wire [7:0] ecsr;
  wire [4:0] idx;
  wire [1:0] il, cl, gp;
  integer err_count = 0, n_checks = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  nip_ctrl dut (.core_clk(core_clk), .rstn(rstn), .src_irq(irq),
    .src_en(en), .set_prio_we(we), .set_prio_sel(sel),
    .set_prio_lvl(lvl), .get_prio_sel(gsel), .init_strobe(init),
    .ext_csr_we(ew), .ext_csr_wdata(ewd), .trap_req(trap),
    .irq_ack(ack), .irq_ret(ret), .halt_mode(halt), .irq_req_r(req),
    .irq_idx_r(idx), .irq_lvl_r(il), .trap_take_r(tt), .reenter_r(re),
    .cur_lvl_r(cl), .get_prio_r(gp), .wake_r(wk), .ext_csr_r(ecsr));
  nip_core_model core (.core_clk(core_clk), .rstn(rstn),
    .irq_req_r(req), .ack_en(aen), .irq_ack(ack));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task setp(input [18:0] m, input [1:0] l);
    @(posedge core_clk) {we, sel, lvl} <= {1'h1, m, l};
    @(posedge core_clk) we <= 1'h0;
  endtask
  task rd(input [4:0] s, input [1:0] e);
    @(posedge core_clk) gsel <= s;
    tk(1);
    chk("prio", e, gp);
  endtask
  task report_and_stop;
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    tk(1); chk("cur", 2'h0, cl); rd(5'h04, 2'h3);
    setp(19'h00002, 2'h0); rd(5'h01, 2'h3);
    setp(19'h00006, 2'h1); rd(5'h02, 2'h1); rd(5'h13, 2'h0);
    // slow core first: request must stand until acked
    @(posedge core_clk) irq <= 19'h00002;
    tk(3); chk("req", 1'h1, req); chk("idx", 5'h01, idx);
    chk("ilvl", 2'h1, il);
    @(posedge core_clk) aen <= 1'h1;
    tk(3); chk("cur", 2'h1, cl);
    setp(19'h00002, 2'h3); #1 chk("reent", 1'h1, re);
    tk(2); chk("cur", 2'h3, cl);
    setp(19'h00002, 2'h2); #1 chk("reent", 1'h0, re);
    tk(2); chk("cur", 2'h3, cl);
    rd(5'h01, 2'h2);
    @(posedge core_clk) {trap, irq} <= {1'h1, 19'h00000};
    @(posedge core_clk) trap <= 1'h0;
    #1 chk("trap", 1'h1, tt);
    // extra returns on an empty stack are ignored
    @(posedge core_clk) ret <= 1'h1;
    repeat (3) @(posedge core_clk);
    @(posedge core_clk) ret <= 1'h0;
    tk(1); chk("cur", 2'h0, cl);
    // timer a at level one loses to timer b at level three
    setp(19'h00080, 2'h1);
    @(posedge core_clk) {halt, irq} <= {1'h1, 19'h00180};
    tk(2); chk("wake", 1'h0, wk);
    chk("idx", 5'h08, idx); chk("ilvl", 2'h3, il);
    @(posedge core_clk) {en, irq} <= {19'h7FFFD, 19'h00182};
    tk(2); chk("wake", 1'h0, wk);
    @(posedge core_clk) en <= 19'h7FFFF;
    tk(2); chk("wake", 1'h1, wk);
    @(posedge core_clk) {ew, ewd} <= {1'h1, 8'hA5};
    @(posedge core_clk) ew <= 1'h0;
    #1 chk("csr", 8'hA5, ecsr);
    @(posedge core_clk) {init, halt, irq} <= {2'h2, 19'h00000};
    @(posedge core_clk) init <= 1'h0;
    #1 chk("csr", 8'h00, ecsr);
    rd(5'h01, 2'h3); rd(5'h02, 2'h3);
    report_and_stop;
  end
endmodule
